// ### pwr_pkg.sv
package pwr_pkg;
    // ********************************
    // power states
    // ********************************
    typedef enum logic [2:0] {
        st_off = 3'h0,
        st_seq = 3'h1,
        st_run = 3'h3,
        st_s3 = 3'h2,
        st_deep = 3'h6
    } pwr_state_t;

    // sleep targets requested by firmware
    localparam logic [1:0] SLEEP_NONE = 2'h0;
    localparam logic [1:0] SLEEP_S3 = 2'h1;
    localparam logic [1:0] SLEEP_S5 = 2'h2;

    // button action selection
    localparam logic [1:0] BTN_TOGGLE = 2'h0;
    localparam logic [1:0] BTN_EVENT_ONLY = 2'h1;
    localparam logic [1:0] BTN_OFF_ONLY = 2'h2;

    localparam int SYNC_STAGES = 2;
    localparam int CLK_MHZ = 100;
    localparam int SEQ_TIME_US = 10;
    localparam int SEQ_CYCLES = SEQ_TIME_US * CLK_MHZ;

    typedef struct packed {
        logic [1:0] btn_mode;     // button action
        logic [1:0] sleep_req;    // sleep target
        logic deep_enable;        // allow deep sleep
        logic deep_keep_ctx;      // context kept in deep sleep entered from S3
    } pwr_cfg_t;

    typedef struct packed {
        logic reset_n;            // module reset out
        logic supply_on_request_n;
        logic deep_sleep_state;
        logic context_kept;
        logic button_event;
        logic [2:0] state;
    } pwr_status_t;
endpackage : pwr_pkg

// ### pwr_sync.sv
`timescale 1ns/1ps
`default_nettype none
module pwr_sync #(
    parameter int STAGES = 2
) (
    input wire logic clk_sys,    // clock
    input wire logic rstn,       // sync reset
    input wire logic ce,         // clock enable
    input wire logic async_in,   // raw input
    input wire logic reset_val,  // value held in reset
    output logic sync_out        // synchronised
);
    logic [STAGES-1:0] stage;
    logic [STAGES-1:0] next_stage;

    // elaboration guard: one flop alone is no synchroniser
    if (STAGES < 2) begin : g_bad_stages
        $error("pwr_sync needs two stages");
    end

    always_comb begin
        next_stage = {stage[STAGES-2:0], async_in};
    end

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            stage <= {STAGES{reset_val}};
        end else if (ce) begin
            stage <= next_stage;
        end
    end

    assign sync_out = stage[STAGES-1];
endmodule : pwr_sync
`default_nettype wire

// ### module_power_control.sv
`timescale 1ns/1ps
`default_nettype none
// Function
// - onboard sequencing starts only once power good reads high.
// - the module stays in reset while power good is low.
// - an undriven power good reads high through the pull and power-up completes.
// - an active-low supply-on request turns on the main supply outputs.
// - a button press is an operator request to toggle power, as configured.
// - deep sleep removes all power but minimal logic watching a few wake events.
// - leaving deep sleep returns to the sleep state it was entered from.
// - context kept in deep sleep depends on the entry condition.
module module_power_control
    import pwr_pkg::*;
#(
    parameter int SEQ_LEN = pwr_pkg::SEQ_CYCLES
) (
    input wire logic clk_sys,                 // standby clock
    input wire logic rstn,                    // sync reset, low active
    input wire logic ce,                      // clock enable
    input wire logic power_good_in,           // carrier power good
    input wire logic power_button_n,          // debounced button, low active
    input wire logic wake_event,              // limited wake source
    input wire pwr_pkg::pwr_cfg_t cfg,        // firmware settings
    output logic supply_on_request_n,         // supply on, low active
    output logic module_reset_n,              // onboard reset, low active
    output logic rails_enable,                // onboard regulators on
    output logic deep_sleep_state,            // in deep sleep
    output logic button_event,                // one-cycle press pulse
    output pwr_pkg::pwr_status_t status       // status word
);
    import pwr_pkg::*;

    // elaboration guard: the count must fit the 16-bit counter
    if (SEQ_LEN < 1 || SEQ_LEN > 65535) begin : g_bad_len
        $error("SEQ_LEN out of range");
    end

    // ********************************
    // input synchronisers
    // ********************************
    logic pg_s;
    logic btn_s;

    pwr_sync #(.STAGES(SYNC_STAGES)) u_pg_sync (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .ce(ce),
        .async_in(power_good_in),
        .reset_val(1'b0),
        .sync_out(pg_s)
    );

    pwr_sync #(.STAGES(SYNC_STAGES)) u_btn_sync (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .ce(ce),
        .async_in(~power_button_n),
        .reset_val(1'b0),
        .sync_out(btn_s)
    );

    // ********************************
    // button edge
    // ********************************
    logic btn_prev;
    logic next_btn_prev;
    logic press;

    always_comb begin
        next_btn_prev = btn_s;
        press = btn_s & ~btn_prev;
    end

    // ********************************
    // power state machine
    // ********************************
    pwr_state_t state;
    pwr_state_t next_state;
    pwr_state_t deep_from;
    pwr_state_t next_deep_from;
    logic [15:0] seq_cnt;
    logic [15:0] next_seq_cnt;
    logic on_req;
    logic next_on_req;
    logic ctx_kept;
    logic next_ctx_kept;
    logic btn_pulse;
    logic next_btn_pulse;
    logic toggle;

    always_comb begin
        next_state = state;
        next_deep_from = deep_from;
        next_seq_cnt = seq_cnt;
        next_on_req = on_req;
        next_ctx_kept = ctx_kept;
        next_btn_pulse = press;
        toggle = press & (cfg.btn_mode != BTN_EVENT_ONLY);
        case (state)
            st_off: begin
                next_seq_cnt = '0;
                if (toggle && cfg.btn_mode != BTN_OFF_ONLY) begin
                    next_on_req = 1'b1;
                    next_state = st_seq;
                end else if (cfg.deep_enable) begin
                    next_deep_from = st_off;
                    next_ctx_kept = 1'b0;
                    next_state = st_deep;
                end
            end
            st_seq: begin
                if (toggle) begin
                    next_on_req = 1'b0;
                    next_state = st_off;
                end else if (!pg_s) begin
                    next_seq_cnt = '0;
                end else if (seq_cnt == 16'(SEQ_LEN - 1)) begin
                    next_state = st_run;
                end else begin
                    next_seq_cnt = seq_cnt + 16'h0001;
                end
            end
            st_run: begin
                if (toggle || cfg.sleep_req == SLEEP_S5) begin
                    next_on_req = 1'b0;
                    next_state = st_off;
                end else if (cfg.sleep_req == SLEEP_S3) begin
                    next_on_req = 1'b0;
                    next_state = st_s3;
                end else if (!pg_s) begin
                    next_seq_cnt = '0;
                    next_state = st_seq;
                end
            end
            st_s3: begin
                if (toggle || wake_event) begin
                    next_on_req = 1'b1;
                    next_seq_cnt = '0;
                    next_state = st_seq;
                end else if (cfg.deep_enable) begin
                    next_deep_from = st_s3;
                    next_ctx_kept = cfg.deep_keep_ctx;
                    next_state = st_deep;
                end
            end
            st_deep: begin
                if (press || wake_event) begin
                    next_state = deep_from;
                end
            end
            default: begin
                next_on_req = 1'b0;
                next_state = st_off;
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            state <= st_off;
            deep_from <= st_off;
            seq_cnt <= '0;
            on_req <= 1'b0;
            ctx_kept <= 1'b0;
            btn_prev <= 1'b0;
            btn_pulse <= 1'b0;
        end else if (ce) begin
            state <= next_state;
            deep_from <= next_deep_from;
            seq_cnt <= next_seq_cnt;
            on_req <= next_on_req;
            ctx_kept <= next_ctx_kept;
            btn_prev <= next_btn_prev;
            btn_pulse <= next_btn_pulse;
        end
    end

    // ********************************
    // outputs
    // ********************************
    assign supply_on_request_n = ~on_req;
    assign module_reset_n = (state == st_run) & pg_s;
    assign rails_enable = on_req & pg_s & (state == st_seq || state == st_run);
    assign deep_sleep_state = (state == st_deep);
    assign button_event = btn_pulse;
    assign status = '{reset_n: module_reset_n, supply_on_request_n: supply_on_request_n,
                      deep_sleep_state: deep_sleep_state, context_kept: ctx_kept,
                      button_event: btn_pulse, state: state};

    // ********************************
    // checks
    // ********************************
    reset_while_low_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        !pg_s |-> !module_reset_n) else $error("reset released while power good low");
    seq_gate_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        (ce && state == st_seq && !pg_s && !press) |=> seq_cnt == 16'h0000)
        else $error("sequencing advanced without power good");
    run_needs_seq_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        (ce && state == st_seq && next_state == st_run) |-> pg_s && seq_cnt == 16'(SEQ_LEN - 1))
        else $error("run entered early");
    supply_on_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        state == st_run |-> !supply_on_request_n) else $error("supply off while running");
    press_toggles_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        (ce && state == st_run && press && cfg.btn_mode == BTN_TOGGLE) |=> state == st_off)
        else $error("press did not switch off");
    deep_off_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        deep_sleep_state |-> supply_on_request_n && !rails_enable) else $error("power in deep sleep");
    deep_return_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        (ce && state == st_deep && wake_event) |=> state == $past(deep_from))
        else $error("deep sleep resumed to wrong state");
    ctx_entry_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        (ce && state == st_off && next_state == st_deep) |=> !ctx_kept)
        else $error("context kept from soft off");
    sync_delay_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        (ce && $past(ce) && $past(ce, 2) && !power_good_in && !$past(power_good_in)) |=> !pg_s)
        else $error("power good used before synchronising");
endmodule : module_power_control
`default_nettype wire

// ### pwr_carrier_model.sv
`timescale 1ns/1ps
`default_nettype none
module pwr_carrier_model #(
    parameter int PG_DLY = 20
) (
    input wire logic clk_sys,             // standby clock
    input wire logic supply_on_request_n, // supply on, low active
    input wire logic hold_low,            // keep module in reset
    input wire logic press,               // operator presses button
    output wire logic power_good_in,      // power good, pulled up
    output wire logic power_button_n      // button, pulled up
);
    int cnt = 0;
    logic supply_main_on;
    logic drive_low;
    tri1 pg_line;
    tri1 btn_line;
    // standby-powered inverter feeding the supply's on control
    assign supply_main_on = (supply_on_request_n === 1'h0);
    // rails settle, then an extra delay before power good is let go
    always @(posedge clk_sys) begin
        if (!supply_main_on) begin
            cnt <= 0;
        end else if (cnt < PG_DLY) begin
            cnt <= cnt + 1;
        end
    end
    assign drive_low = hold_low | (cnt < PG_DLY);
    // released line floats to the pull-up, never driven high
    assign pg_line = drive_low ? 1'h0 : 1'hz;
    assign btn_line = press ? 1'h0 : 1'hz;
    assign power_good_in = pg_line;
    assign power_button_n = btn_line;
endmodule : pwr_carrier_model
`default_nettype wire

// ### module_power_control_tb.sv
`timescale 1ns/1ps
`default_nettype none
module module_power_control_tb;
    import pwr_pkg::*;
    localparam int SEQ = 4;
    localparam int PG_DLY = 20;
    logic clk_sys;
    logic rstn;
    logic ce;
    logic hold_low;
    logic press;
    logic wake_event;
    pwr_cfg_t cfg;
    wire logic power_good_in;
    wire logic power_button_n;
    logic supply_on_request_n;
    logic module_reset_n;
    logic rails_enable;
    logic deep_sleep_state;
    logic button_event;
    pwr_status_t status;
    int err_count = 0;
    int n_checks = 0;
    int n_evt = 0;
    int cycles = 0;
    int n0;

    module_power_control #(.SEQ_LEN(SEQ)) i_module_power_control (
        .clk_sys(clk_sys), .rstn(rstn), .ce(ce), .power_good_in(power_good_in),
        .power_button_n(power_button_n), .wake_event(wake_event), .cfg(cfg),
        .supply_on_request_n(supply_on_request_n), .module_reset_n(module_reset_n),
        .rails_enable(rails_enable), .deep_sleep_state(deep_sleep_state),
        .button_event(button_event), .status(status));
    pwr_carrier_model #(.PG_DLY(PG_DLY)) i_pwr_carrier_model (
        .clk_sys(clk_sys), .supply_on_request_n(supply_on_request_n), .hold_low(hold_low),
        .press(press), .power_good_in(power_good_in), .power_button_n(power_button_n));

    initial begin
        clk_sys = 1'h0;
        forever #5 clk_sys = ~clk_sys;
    end

    // ****************************************
    // helpers
    // ****************************************
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (button_event === 1'h1) begin
            n_evt <= n_evt + 1;
        end
        if (cycles == 2000) begin
            err_count = err_count + 1;
            tally_and_finish();
        end
    end

    task automatic tally_and_finish;
        $display("checks %0d errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : tally_and_finish

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic ticks(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : ticks

    task automatic push;
        @(posedge clk_sys);
        press <= 1'h1;
        ticks(4);
        @(posedge clk_sys);
        press <= 1'h0;
        ticks(1);
    endtask : push

    task automatic wake_pulse;
        @(posedge clk_sys);
        wake_event <= 1'h1;
        @(posedge clk_sys);
        wake_event <= 1'h0;
        ticks(4);
    endtask : wake_pulse

    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_soft_off_deep;
        @(posedge clk_sys);
        cfg.deep_enable <= 1'h1;
        cfg.deep_keep_ctx <= 1'h1;
        ticks(6);
        chk({deep_sleep_state, status.context_kept, rails_enable}, 8'h04);
        @(posedge clk_sys);
        cfg.deep_enable <= 1'h0;
        wake_pulse();
        chk({deep_sleep_state, status.state}, {4'h0, st_off});
    endtask : t_soft_off_deep

    task automatic t_power_up;
        n0 = n_evt;
        push();
        chk(supply_on_request_n, 8'h00);
        chk(8'(n_evt - n0), 8'h01);
        chk(module_reset_n, 8'h00);
        ticks(16);
        chk(module_reset_n, 8'h00);
        ticks(14);
        chk({module_reset_n, status.state}, {4'h1, st_run});
    endtask : t_power_up

    task automatic t_pg_loss;
        @(posedge clk_sys);
        hold_low <= 1'h1;
        ticks(5);
        chk({module_reset_n, status.state}, {4'h0, st_seq});
        @(posedge clk_sys);
        hold_low <= 1'h0;
        ticks(12);
        chk({module_reset_n, status.state}, {4'h1, st_run});
    endtask : t_pg_loss

    task automatic t_s3_deep;
        @(posedge clk_sys);
        cfg.sleep_req <= SLEEP_S3;
        ticks(4);
        chk({supply_on_request_n, status.state}, {4'h1, st_s3});
        @(posedge clk_sys);
        cfg.sleep_req <= SLEEP_NONE;
        cfg.deep_enable <= 1'h1;
        ticks(4);
        chk({deep_sleep_state, status.context_kept, rails_enable}, 8'h06);
        @(posedge clk_sys);
        cfg.deep_enable <= 1'h0;
        wake_pulse();
        chk({deep_sleep_state, status.state}, {4'h0, st_s3});
    endtask : t_s3_deep

    task automatic t_button_modes;
        @(posedge clk_sys);
        cfg.btn_mode <= BTN_EVENT_ONLY;
        n0 = n_evt;
        push();
        chk(8'(n_evt - n0), 8'h01);
        chk(status.state, {5'h00, st_s3});
        @(posedge clk_sys);
        cfg.btn_mode <= BTN_TOGGLE;
        push();
        chk({supply_on_request_n, status.state}, {4'h0, st_seq});
    endtask : t_button_modes

    task automatic t_ce_freeze;
        @(posedge clk_sys);
        ce <= 1'h0;
        ticks(30);
        chk({module_reset_n, rails_enable, status.state}, {5'h00, st_seq});
        @(posedge clk_sys);
        ce <= 1'h1;
        ticks(8);
        chk({module_reset_n, status.state}, {4'h1, st_run});
    endtask : t_ce_freeze

    task automatic t_off_modes;
        @(posedge clk_sys);
        cfg.sleep_req <= SLEEP_S5;
        cfg.btn_mode <= BTN_OFF_ONLY;
        ticks(3);
        chk({supply_on_request_n, status.state}, {4'h1, st_off});
        @(posedge clk_sys);
        cfg.sleep_req <= SLEEP_NONE;
        n0 = n_evt;
        push();
        chk(8'(n_evt - n0), 8'h01);
        chk({supply_on_request_n, status.state}, {4'h1, st_off});
        @(posedge clk_sys);
        cfg.btn_mode <= BTN_TOGGLE;
        push();
        chk({supply_on_request_n, status.state}, {4'h0, st_seq});
    endtask : t_off_modes

    task automatic t_mid_reset;
        @(posedge clk_sys);
        rstn <= 1'h0;
        ticks(2);
        chk({supply_on_request_n, module_reset_n, rails_enable, status.state}, 8'h20);
        @(posedge clk_sys);
        rstn <= 1'h1;
        ticks(2);
        chk({supply_on_request_n, deep_sleep_state, status.state}, 8'h10);
    endtask : t_mid_reset

    initial begin
        rstn = 1'h0;
        ce = 1'h1;
        hold_low = 1'h0;
        press = 1'h0;
        wake_event = 1'h0;
        cfg = '0;
        ticks(20);
        chk({supply_on_request_n, module_reset_n, rails_enable, deep_sleep_state}, 8'h08);
        chk({button_event, status.state}, {4'h0, st_off});
        @(posedge clk_sys);
        rstn <= 1'h1;
        ticks(2);
        t_soft_off_deep();
        t_power_up();
        t_pg_loss();
        t_s3_deep();
        t_button_modes();
        t_ce_freeze();
        t_off_modes();
        t_mid_reset();
        tally_and_finish();
    end
endmodule : module_power_control_tb
`default_nettype wire
